// *** lmsp_pkg.sv ***
// How it works
// - a read of the soft reset register at function page 0x11 returns every register to default.
// - at power-up every register loads its default, so the display starts blank.
// - the twelve row switches are enabled one at a time in fixed order, each lighting its row.
// - each row on-period lasts one 128 us scan slot, then an 8 us blanking gap follows.
// - a row switch output is active low, pulled low while its row is lit.
// - one 8-bit global current scale sets all column source currents as value/256.
// - every LED has its own 8-bit PWM register, setting its on-fraction as value/256.
// - the PWM value is a linear step index, so value four lights for four of 256 steps.
// - each dot has exactly two modes, direct PWM and automatic breathing.
// - a dot runs direct PWM when its breath-mode code is 00 or global breath enable is clear.
// - breath-mode codes 01, 10 and 11 select breath patterns one, two and three.
package lmsp_pkg;
	localparam int CLK_MHZ        = 250;
	localparam int SCAN_SLOT_NS   = 128000;
	localparam int NONOVERLAP_NS  = 8000;
	localparam int SCAN_SLOT_CYC  = (SCAN_SLOT_NS * CLK_MHZ + 999) / 1000;
	localparam int NONOVERLAP_CYC = (NONOVERLAP_NS * CLK_MHZ + 999) / 1000;

	localparam int ROWS       = 12;
	localparam int COLS       = 12;
	localparam int ROW_W      = 4;
	localparam int PWM_W      = 8;
	localparam int PWM_STEPS  = 256;
	localparam int PAGE_DEPTH = 192;
	localparam int PATTERNS   = 3;

	localparam logic [1:0] PAGE_PWM    = 2'h1;
	localparam logic [1:0] PAGE_BREATH = 2'h2;
	localparam logic [1:0] PAGE_FUNC   = 2'h3;

	localparam logic [7:0] REG_CONFIG      = 8'h00;
	localparam logic [7:0] REG_GLOBAL_SCALE = 8'h01;
	localparam logic [7:0] REG_SOFT_RESET  = 8'h11;
	localparam logic [7:0] PAGE_LAST_ADDR  = 8'hBF;

	localparam int         CFG_BREATH_EN_BIT = 1;
	localparam logic [7:0] CONFIG_RESET      = 8'h00;
	localparam logic [7:0] GLOBAL_SCALE_RESET = 8'h00;
	localparam logic [7:0] PWM_RESET         = 8'h00;
	localparam logic [1:0] MODE_PWM          = 2'h0;
	localparam logic [7:0] RDATA_IDLE        = 8'h00;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lmsp_reg_req_t;

	typedef enum logic {LMSP_SLOT, LMSP_GAP} lmsp_scan_st_t;
endpackage

// *** lmsp_scan_timer.sv ***
`timescale 1ns/1ps
module lmsp_scan_timer #(
	parameter int SLOT_CYC = lmsp_pkg::SCAN_SLOT_CYC,
	parameter int GAP_CYC  = lmsp_pkg::NONOVERLAP_CYC
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_srst,
	output logic [lmsp_pkg::ROW_W-1:0]     o_row,
	output logic                           o_in_slot,
	output logic [lmsp_pkg::PWM_W-1:0]     o_step
);
	localparam int STEP_CYC = SLOT_CYC / lmsp_pkg::PWM_STEPS;
	localparam int CW       = $clog2(SLOT_CYC + GAP_CYC + 1);

	lmsp_pkg::lmsp_scan_st_t        state, next_state;
	logic [CW-1:0]                  cnt, next_cnt;
	logic [lmsp_pkg::PWM_W-1:0]     step, next_step;
	logic [lmsp_pkg::ROW_W-1:0]     row, next_row;

	// slot of 256 pwm steps, then blanking gap, then next row
	always_comb begin
		next_state = state;
		next_cnt   = cnt + CW'(1);
		next_step  = step;
		next_row   = row;
		case (state)
			lmsp_pkg::LMSP_SLOT: begin
				if (cnt == CW'(STEP_CYC - 1)) begin
					next_cnt  = '0;
					next_step = step + 8'h01;
					if (step == 8'hFF) begin
						next_state = lmsp_pkg::LMSP_GAP;
					end
				end
			end
			lmsp_pkg::LMSP_GAP: begin
				if (cnt == CW'(GAP_CYC - 1)) begin
					next_cnt   = '0;
					next_state = lmsp_pkg::LMSP_SLOT;
					next_row   = (row == 4'(lmsp_pkg::ROWS - 1)) ? 4'h0 : row + 4'h1;
				end
			end
			default: begin
				next_state = lmsp_pkg::LMSP_SLOT;
				next_cnt   = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= lmsp_pkg::LMSP_SLOT;
			cnt   <= '0;
			step  <= '0;
			row   <= '0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
			step  <= next_step;
			row   <= next_row;
		end
	end

	assign o_row     = row;
	assign o_in_slot = (state == lmsp_pkg::LMSP_SLOT);
	assign o_step    = step;
endmodule

// *** lmsp_pwm_gate.sv ***
`timescale 1ns/1ps
module lmsp_pwm_gate #(
	parameter int N = lmsp_pkg::COLS,
	parameter int W = lmsp_pkg::PWM_W
) (
	input  wire logic [N-1:0][W-1:0] i_duty,
	input  wire logic [W-1:0]        i_step,
	input  wire logic                i_enable,
	output logic [N-1:0]             o_on
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_col
			// on while the linear step index is below the duty value
			assign o_on[g] = i_enable && (i_step < i_duty[g]);
		end
	endgenerate
endmodule

// *** lmsp_led_matrix_scan_pwm.sv ***
`timescale 1ns/1ps
module lmsp_led_matrix_scan_pwm #(
	parameter int SLOT_CYC = lmsp_pkg::SCAN_SLOT_CYC,
	parameter int GAP_CYC  = lmsp_pkg::NONOVERLAP_CYC
) (
	input  wire logic                                              i_clk,
	input  wire logic                                              i_srst,
	input  wire lmsp_pkg::lmsp_reg_req_t                           i_reg,
	input  wire logic [lmsp_pkg::PATTERNS-1:0][lmsp_pkg::PWM_W-1:0] i_breath_level,
	output logic [7:0]                                             o_reg_rdata,
	output logic [lmsp_pkg::ROWS-1:0]                              o_row_switch_n,
	output logic [lmsp_pkg::COLS-1:0]                              o_column_source,
	output logic [7:0]                                             o_current_scale,
	output logic                                                   o_breath_en
);
	function automatic logic reg_hit(input lmsp_pkg::lmsp_reg_req_t r,
			input logic [1:0] page, input logic [7:0] addr);
		reg_hit = (r.page == page) && (r.addr == addr);
	endfunction

	function automatic logic [7:0] led_addr(input logic [3:0] row, input logic [3:0] col);
		led_addr = {row, col};
	endfunction

	logic [7:0] pwm_mem  [lmsp_pkg::PAGE_DEPTH];
	logic [1:0] mode_mem [lmsp_pkg::PAGE_DEPTH];

	logic       soft_rst, next_soft_rst;
	logic       any_rst;
	logic [7:0] config_reg, next_config_reg;
	logic [7:0] global_scale, next_global_scale;
	logic [7:0] rdata, next_rdata;
	logic       in_page;
	logic       breath_en;

	assign any_rst   = i_srst | soft_rst;
	assign in_page   = (i_reg.addr <= lmsp_pkg::PAGE_LAST_ADDR);
	assign breath_en = config_reg[lmsp_pkg::CFG_BREATH_EN_BIT];

	// register port: writes, reads and the read-triggered reset
	always_comb begin
		next_config_reg   = config_reg;
		next_global_scale = global_scale;
		next_soft_rst     = 1'b0;
		next_rdata        = rdata;
		if (i_reg.wr) begin
			if (reg_hit(i_reg, lmsp_pkg::PAGE_FUNC, lmsp_pkg::REG_CONFIG)) begin
				next_config_reg = i_reg.wdata;
			end
			if (reg_hit(i_reg, lmsp_pkg::PAGE_FUNC, lmsp_pkg::REG_GLOBAL_SCALE)) begin
				next_global_scale = i_reg.wdata;
			end
		end
		if (i_reg.rd) begin
			next_rdata = lmsp_pkg::RDATA_IDLE;
			case (i_reg.page)
				lmsp_pkg::PAGE_PWM: begin
					if (in_page) begin
						next_rdata = pwm_mem[i_reg.addr];
					end
				end
				lmsp_pkg::PAGE_BREATH: begin
					if (in_page) begin
						next_rdata = {6'h00, mode_mem[i_reg.addr]};
					end
				end
				lmsp_pkg::PAGE_FUNC: begin
					if (i_reg.addr == lmsp_pkg::REG_CONFIG) begin
						next_rdata = config_reg;
					end
					if (i_reg.addr == lmsp_pkg::REG_GLOBAL_SCALE) begin
						next_rdata = global_scale;
					end
				end
				default: begin
					next_rdata = lmsp_pkg::RDATA_IDLE;
				end
			endcase
			if (reg_hit(i_reg, lmsp_pkg::PAGE_FUNC, lmsp_pkg::REG_SOFT_RESET) && !soft_rst) begin
				next_soft_rst = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			soft_rst <= 1'b0;
			rdata    <= lmsp_pkg::RDATA_IDLE;
		end else begin
			soft_rst <= next_soft_rst;
			rdata    <= next_rdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (any_rst) begin
			config_reg   <= lmsp_pkg::CONFIG_RESET;
			global_scale <= lmsp_pkg::GLOBAL_SCALE_RESET;
		end else begin
			config_reg   <= next_config_reg;
			global_scale <= next_global_scale;
		end
	end

	// per-led pwm values and breath-mode codes
	always_ff @(posedge i_clk) begin
		if (any_rst) begin
			for (int i = 0; i < lmsp_pkg::PAGE_DEPTH; i++) begin
				pwm_mem[i]  <= lmsp_pkg::PWM_RESET;
				mode_mem[i] <= lmsp_pkg::MODE_PWM;
			end
		end else if (i_reg.wr && in_page) begin
			if (i_reg.page == lmsp_pkg::PAGE_PWM) begin
				pwm_mem[i_reg.addr] <= i_reg.wdata;
			end
			if (i_reg.page == lmsp_pkg::PAGE_BREATH) begin
				mode_mem[i_reg.addr] <= i_reg.wdata[1:0];
			end
		end
	end

	logic [lmsp_pkg::ROW_W-1:0]                     row;
	logic                                           in_slot;
	logic [lmsp_pkg::PWM_W-1:0]                     step;
	logic [lmsp_pkg::COLS-1:0][lmsp_pkg::PWM_W-1:0] duty;
	logic [lmsp_pkg::COLS-1:0]                      col_on;

	lmsp_scan_timer #(
		.SLOT_CYC (SLOT_CYC),
		.GAP_CYC  (GAP_CYC)
	) u_timer (
		.i_clk     (i_clk),
		.i_srst    (i_srst),
		.o_row     (row),
		.o_in_slot (in_slot),
		.o_step    (step)
	);

	// each dot: direct pwm or one of three breath patterns
	always_comb begin
		logic [7:0] a;
		logic [1:0] m;
		a = 8'h00;
		m = 2'h0;
		for (int c = 0; c < lmsp_pkg::COLS; c++) begin
			a = led_addr(row, 4'(c));
			m = mode_mem[a];
			if (!breath_en || m == lmsp_pkg::MODE_PWM) begin
				duty[c] = pwm_mem[a];
			end else begin
				duty[c] = i_breath_level[m - 2'h1];
			end
		end
	end

	lmsp_pwm_gate #(
		.N (lmsp_pkg::COLS),
		.W (lmsp_pkg::PWM_W)
	) u_gate (
		.i_duty   (duty),
		.i_step   (step),
		.i_enable (in_slot),
		.o_on     (col_on)
	);

	logic [lmsp_pkg::ROWS-1:0] next_row_switch_n;
	logic [lmsp_pkg::COLS-1:0] next_column_source;

	always_comb begin
		next_row_switch_n = '1;
		if (in_slot) begin
			next_row_switch_n[row] = 1'b0;
		end
		next_column_source = in_slot ? col_on : '0;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_row_switch_n  <= '1;
			o_column_source <= '0;
			o_current_scale <= lmsp_pkg::GLOBAL_SCALE_RESET;
			o_breath_en     <= 1'b0;
		end else begin
			o_row_switch_n  <= next_row_switch_n;
			o_column_source <= next_column_source;
			o_current_scale <= global_scale;
			o_breath_en     <= breath_en;
		end
	end

	assign o_reg_rdata = rdata;

	// checking helpers
	logic [31:0] on_len;
	logic [31:0] off_len;
	logic        seen_on;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			on_len  <= '0;
			off_len <= '0;
			seen_on <= 1'b0;
		end else begin
			on_len  <= (&o_row_switch_n) ? 32'h0 : on_len + 32'h1;
			off_len <= (&o_row_switch_n) ? off_len + 32'h1 : 32'h0;
			seen_on <= seen_on | ~(&o_row_switch_n);
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	chk_soft_reset_clear: assert property (
		(i_reg.rd && reg_hit(i_reg, lmsp_pkg::PAGE_FUNC, lmsp_pkg::REG_SOFT_RESET) && !soft_rst)
		|-> ##2 (global_scale == lmsp_pkg::GLOBAL_SCALE_RESET && config_reg == lmsp_pkg::CONFIG_RESET))
		else $error("soft reset read did not clear registers");

	chk_powerup_blank: assert property (
		$fell(i_srst) |-> (o_column_source == '0 && global_scale == lmsp_pkg::GLOBAL_SCALE_RESET))
		else $error("display not blank after reset");

	chk_one_row_on: assert property (
		$countones(~o_row_switch_n) <= 1)
		else $error("more than one row switch active");

	chk_slot_length: assert property (
		$rose(&o_row_switch_n) |-> on_len == 32'(SLOT_CYC))
		else $error("row on period has wrong length");

	chk_gap_length: assert property (
		($fell(&o_row_switch_n) && seen_on) |-> off_len == 32'(GAP_CYC))
		else $error("blanking gap has wrong length");

	chk_gap_cols_off: assert property (
		(&o_row_switch_n) |-> o_column_source == '0)
		else $error("column source on during blanking gap");

	chk_scale_drives_out: assert property (
		(i_reg.wr && !i_reg.rd && !soft_rst
			&& reg_hit(i_reg, lmsp_pkg::PAGE_FUNC, lmsp_pkg::REG_GLOBAL_SCALE))
		|-> ##2 o_current_scale == $past(i_reg.wdata, 2))
		else $error("global current scale not applied");

	chk_zero_pwm_off: assert property (
		(duty[0] == 8'h00) |=> !o_column_source[0])
		else $error("column on with zero duty");

	chk_step_compare: assert property (
		(in_slot && step < duty[0]) |=> o_column_source[0])
		else $error("column off below its duty step");

	chk_pwm_mode_select: assert property (
		(!breath_en || mode_mem[led_addr(row, 4'h0)] == lmsp_pkg::MODE_PWM)
		|-> duty[0] == pwm_mem[led_addr(row, 4'h0)])
		else $error("pwm mode dot not using its pwm register");

	chk_breath_select: assert property (
		(breath_en && mode_mem[led_addr(row, 4'h0)] != lmsp_pkg::MODE_PWM)
		|-> duty[0] == i_breath_level[mode_mem[led_addr(row, 4'h0)] - 2'h1])
		else $error("breath dot not using its pattern level");

	chk_row_advance: assert property (
		$rose(in_slot)
		|-> row == (($past(row) == 4'(lmsp_pkg::ROWS - 1)) ? 4'h0 : $past(row) + 4'h1))
		else $error("row switch order broken");

	chk_row_active_low: assert property (
		in_slot |=> !o_row_switch_n[$past(row)])
		else $error("selected row switch not pulled low");

	chk_gap_rows_off: assert property (
		!in_slot |=> (&o_row_switch_n))
		else $error("row switch on during blanking gap");

	chk_reset_outputs: assert property (
		$fell(i_srst) |-> ((&o_row_switch_n) && !o_breath_en
			&& o_current_scale == lmsp_pkg::GLOBAL_SCALE_RESET
			&& o_reg_rdata == lmsp_pkg::RDATA_IDLE))
		else $error("outputs not at default after reset");

	chk_soft_reset_mem: assert property (
		soft_rst |=> (pwm_mem[led_addr(row, 4'h0)] == lmsp_pkg::PWM_RESET
			&& mode_mem[led_addr(row, 4'h0)] == lmsp_pkg::MODE_PWM))
		else $error("soft reset did not clear led registers");

	chk_pwm_write_lands: assert property (
		(i_reg.wr && i_reg.page == lmsp_pkg::PAGE_PWM && in_page && !soft_rst)
		|=> pwm_mem[$past(i_reg.addr)] == $past(i_reg.wdata))
		else $error("pwm register write lost");

	chk_mode_write_lands: assert property (
		(i_reg.wr && i_reg.page == lmsp_pkg::PAGE_BREATH && in_page && !soft_rst)
		|=> mode_mem[$past(i_reg.addr)] == $past(i_reg.wdata[1:0]))
		else $error("breath mode write lost");

	chk_pwm_read_back: assert property (
		(i_reg.rd && i_reg.page == lmsp_pkg::PAGE_PWM && in_page)
		|=> o_reg_rdata == $past(pwm_mem[i_reg.addr]))
		else $error("pwm register read returned wrong data");

	chk_scale_read_back: assert property (
		(i_reg.rd && reg_hit(i_reg, lmsp_pkg::PAGE_FUNC, lmsp_pkg::REG_GLOBAL_SCALE))
		|=> o_reg_rdata == $past(global_scale))
		else $error("global current scale read returned wrong data");

	chk_breath_en_out: assert property (
		o_breath_en == $past(breath_en))
		else $error("breath enable output does not follow config");
endmodule

// *** lmsp_matrix_model.sv ***
`timescale 1ns/1ps
module lmsp_matrix_model #(
	parameter int SLOT = 512,
	parameter int GAP  = 4
) (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic [11:0] i_row_n,
	input  wire logic [11:0] i_col,
	output int               o_cnt [12][12],
	output int               o_err
);
	// lit cycles per led of the last slot of each row, plus scan faults seen
	int run;
	int gap;
	int row;
	int nlow;
	always @(posedge i_clk) begin
		nlow = 0;
		for (int i = 0; i < 12; i++) begin
			if (i_row_n[i] === 1'b0)
				nlow++;
		end
		if (i_srst) begin
			run = 0;
			gap = -1000;
			row = 11;
			o_err = 0;
		end else if (nlow > 1) begin
			o_err++;
		end else if (nlow == 0) begin
			if (i_col !== 12'h000)
				o_err++;
			if (run > 0 && run != SLOT)
				o_err++;
			run = 0;
			gap++;
		end else begin
			if (run == 0) begin
				if (gap >= 0 && gap != GAP)
					o_err++;
				row = (row + 1) % 12;
				if (i_row_n[row] !== 1'b0)
					o_err++;
				o_cnt[row] = '{default: 0};
				gap = 0;
			end
			run++;
			for (int c = 0; c < 12; c++) begin
				if (i_col[c] === 1'b1)
					o_cnt[row][c]++;
			end
		end
	end
endmodule

// *** lmsp_led_matrix_scan_pwm_tb.sv ***
`timescale 1ns/1ps
module lmsp_led_matrix_scan_pwm_tb;
	localparam int SLOT = 512;
	localparam int GAP  = 4;
	logic                    i_clk;
	logic                    i_srst;
	lmsp_pkg::lmsp_reg_req_t i_reg;
	logic [2:0][7:0]         lvl;
	logic [7:0]              rdata;
	logic [7:0]              scale;
	logic [7:0]              s;
	logic [11:0]             row_n;
	logic [11:0]             col;
	logic                    ben;
	logic                    be_m;
	int                      cnt [12][12];
	int                      pwm [12][12];
	int                      mode [12][12];
	int                      gam [4] = '{0, 18, 69, 255};
	int                      merr;
	int                      n_fail = 0;
	int                      checked = 0;
	int                      cyc = 0;
	int                      seed;

	lmsp_led_matrix_scan_pwm #(.SLOT_CYC(SLOT), .GAP_CYC(GAP)) lmsp_led_matrix_scan_pwm_i (
		.i_clk(i_clk), .i_srst(i_srst), .i_reg(i_reg), .i_breath_level(lvl),
		.o_reg_rdata(rdata), .o_row_switch_n(row_n), .o_column_source(col),
		.o_current_scale(scale), .o_breath_en(ben));
	lmsp_matrix_model #(.SLOT(SLOT), .GAP(GAP)) lmsp_matrix_model_i (
		.i_clk(i_clk), .i_srst(i_srst), .i_row_n(row_n), .i_col(col),
		.o_cnt(cnt), .o_err(merr));

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// one register access, read data sampled when the strobe drops
	task automatic acc(input logic w, input logic [1:0] pg, input logic [7:0] a,
			input logic [7:0] d);
		@(negedge i_clk);
		i_reg = '{wr: w, rd: !w, page: pg, addr: a, wdata: d};
		@(negedge i_clk);
		i_reg = '0;
	endtask

	task automatic load();
		for (int r = 0; r < 12; r++) begin
			for (int c = 0; c < 12; c++) begin
				pwm[r][c] = (c < 4) ? gam[c] : ($random(seed) & 255);
				mode[r][c] = $random(seed) & 3;
				acc(1'b1, 2'h1, 8'(r * 16 + c), 8'(pwm[r][c]));
				acc(1'b1, 2'h2, 8'(r * 16 + c), 8'(mode[r][c]));
			end
		end
	endtask

	// wait one whole frame started after the last write, then compare every led
	task automatic check_frame();
		int d;
		@(negedge row_n[0]);
		@(negedge row_n[0]);
		@(negedge i_clk);
		for (int r = 0; r < 12; r++) begin
			for (int c = 0; c < 12; c++) begin
				d = (be_m && mode[r][c] != 0) ? lvl[mode[r][c] - 1] : pwm[r][c];
				chk("led_on", 16'(d * SLOT / 256), 16'(cnt[r][c]));
			end
		end
		chk("matrix", 16'h0000, 16'(merr));
	endtask

	initial begin
		seed = 83892;
		i_srst = 1'b1;
		i_reg = '0;
		be_m = 1'b0;
		lvl = 24'($random(seed));
		repeat (5) @(posedge i_clk);
		@(negedge i_clk);
		chk("rows", 16'h0FFF, 16'(row_n));
		chk("cols", 16'h0000, 16'(col));
		chk("breath_en", 16'h0000, 16'(ben));
		chk("scale", 16'h0000, {scale, rdata});
		i_srst = 1'b0;
		load();
		s = 8'($random(seed));
		acc(1'b1, 2'h3, 8'h01, s);
		@(negedge i_clk);
		chk("scale", 16'(s), 16'(scale));
		acc(1'b0, 2'h3, 8'h01, 8'h00);
		chk("scale_rd", 16'(s), 16'(rdata));
		check_frame();
		acc(1'b1, 2'h3, 8'h00, 8'h02);
		be_m = 1'b1;
		@(negedge i_clk);
		chk("breath_en", 16'h0001, 16'(ben));
		check_frame();
		acc(1'b1, 2'h1, 8'hC0, 8'h55);
		acc(1'b0, 2'h1, 8'hC0, 8'h00);
		chk("unmapped", 16'h0000, 16'(rdata));
		acc(1'b0, 2'h1, 8'h15, 8'h00);
		chk("pwm_rd", 16'(pwm[1][5]), 16'(rdata));
		acc(1'b0, 2'h0, 8'h15, 8'h00);
		chk("page0", 16'h0000, 16'(rdata));
		acc(1'b0, 2'h1, 8'h15, 8'h00);
		acc(1'b0, 2'h3, 8'h11, 8'h00);
		chk("soft_rd", 16'h0000, 16'(rdata));
		@(negedge i_clk);
		acc(1'b0, 2'h3, 8'h01, 8'h00);
		chk("ben_def", 16'h0000, 16'(ben));
		chk("scale_def", 16'h0000, {scale, rdata});
		pwm = '{default: 0};
		mode = '{default: 0};
		be_m = 1'b0;
		check_frame();
		complete_run();
	end
endmodule
